// ==== hw/rees_seq.sv ====
// Purpose: Reset entry and exit sequencer of a small microcontroller.
// Assumes: resetn is the power-on master reset, synchronous to sys_clk.
// Notes: Supply-good is a pin and is synchronised before use.
// What this block does
// - Halt the core while in reset.
// - Load special registers with defaults on entry.
// - Disable interrupts and timers on entry.
// - Keep data memory; only stack pointer resets.
// - Port latches all ones, open drain.
// - Pull-ups on during and after reset.
// - Drive reset pin low for supply, power-on.
// - Clear program counter, fetch from zero.
// - Clock select defaults to internal oscillator.
// - Watchdog enabled, clock divided by twelve.
// - Power-on: wait supply-good, then delay.
// - Set power-on flag on power-on exit.
// - Other resets clear the power-on flag.
// - Enable supply monitor after every power-on.
// - No release delay after supply-monitor reset.
// - Only power-on changes supply monitor enable.
//
// The implementer's own choices: the register offsets and strobed register access.
`include "rees_defs.svh"
module rees_seq #(
  parameter int unsigned POR_DELAY_CYC = `REES_POR_DELAY_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Reset requests
  input wire logic supply_good,
  input wire logic other_reset_req,
  // Core and peripheral control
  output logic core_halt,
  output logic sfr_reset,
  output logic irq_timer_disable,
  output logic sp_reset,
  output logic exit_load,
  output logic [15:0] fetch_addr,
  output rees_pkg::rees_clk_src_t clk_sel,
  output logic wdt_en,
  output logic [3:0] wdt_div,
  output logic mon_en,
  // Port pins
  output logic port_force_default,
  output logic [7:0] port_latch_value,
  output logic port_open_drain,
  output logic weak_pullup_en,
  // Reset pin, open drain
  output logic reset_pin_low_out,
  output logic reset_pin_low_oe,
  // Interrupt
  output logic irq
);
  import rees_pkg::*;

  localparam logic [16:0] POR_LAST = 17'(POR_DELAY_CYC - 1);
  localparam logic [2:0] OTHER_LAST = `REES_OTHER_HOLD_CYC - 3'h1;

  rees_state_t state_r;
  rees_state_t state_nxt;
  logic supply_s;
  logic supply_s_d_r;
  logic [16:0] dly_cnt_r;
  logic [2:0] oth_cnt_r;
  logic por_path_r;
  logic sup_path_r;
  logic por_flag_r;
  logic sup_flag_r;
  logic oth_flag_r;
  logic soft_flag_r;
  logic mon_src_r;
  logic pull_dis_r;
  logic [1:0] int_stat_r;
  logic [1:0] int_mask_r;
  logic soft_req;
  logic wr_cause;
  logic wr_mon;
  logic in_run;
  logic supply_trip;
  logic supply_fall;

  // Supply-good comes from the analog side, so it is synchronised.
  rees_sync u_supply_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .pin_in(supply_good),
    .level_out(supply_s)
  );

  // Register writes only land while the core runs; a halted core
  // cannot issue them, and this keeps defaults from being overwritten.
  assign in_run = (state_r == ST_RUN);
  assign wr_cause = reg_wr && in_run && (reg_addr == `REES_ADDR_CAUSE);
  assign wr_mon = reg_wr && in_run && (reg_addr == `REES_ADDR_MON);
  assign soft_req = wr_cause && reg_wdata[`REES_CAUSE_SOFT_BIT];
  assign supply_trip = mon_en && mon_src_r && !supply_s;
  assign supply_fall = supply_s_d_r && !supply_s;

  // Next state of the sequencer.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_POR_HOLD: begin
        if (supply_s) begin
          state_nxt = ST_POR_DELAY;
        end
      end
      ST_POR_DELAY: begin
        if (dly_cnt_r == POR_LAST) begin
          state_nxt = ST_SYNC;
        end
      end
      ST_SUPPLY_HOLD: begin
        if (supply_s) begin
          state_nxt = ST_SYNC;
        end
      end
      ST_OTHER_HOLD: begin
        if (oth_cnt_r == OTHER_LAST) begin
          state_nxt = ST_SYNC;
        end
      end
      ST_SYNC: begin
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (supply_trip) begin
          state_nxt = ST_SUPPLY_HOLD;
        end else if (soft_req || other_reset_req) begin
          state_nxt = ST_OTHER_HOLD;
        end
      end
      default: begin
        state_nxt = ST_POR_HOLD;
      end
    endcase
  end

  // State register; power-on master reset lands in the hold state.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r <= ST_POR_HOLD;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // Hold counters; each restarts whenever its state is not active.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dly_cnt_r <= 17'h00000;
      oth_cnt_r <= 3'h0;
    end else if (clk_en) begin
      if (state_r == ST_POR_DELAY) begin
        dly_cnt_r <= dly_cnt_r + 17'h00001;
      end else begin
        dly_cnt_r <= 17'h00000;
      end
      if (state_r == ST_OTHER_HOLD) begin
        oth_cnt_r <= oth_cnt_r + 3'h1;
      end else begin
        oth_cnt_r <= 3'h0;
      end
    end
  end

  // Which kind of reset is in progress, for the pin and the flags.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      por_path_r <= 1'b1;
      sup_path_r <= 1'b0;
    end else if (clk_en) begin
      if (in_run && state_nxt == ST_SUPPLY_HOLD) begin
        por_path_r <= 1'b0;
        sup_path_r <= 1'b1;
      end else if (in_run && state_nxt == ST_OTHER_HOLD) begin
        por_path_r <= 1'b0;
        sup_path_r <= 1'b0;
      end
    end
  end

  // Reset cause flags. The other flags read zero while the
  // power-on flag is set.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      por_flag_r <= 1'b0;
      sup_flag_r <= 1'b0;
      oth_flag_r <= 1'b0;
      soft_flag_r <= 1'b0;
    end else if (clk_en) begin
      if (state_r == ST_SYNC && por_path_r) begin
        por_flag_r <= 1'b1;
        sup_flag_r <= 1'b0;
        oth_flag_r <= 1'b0;
        soft_flag_r <= 1'b0;
      end else if (in_run && state_nxt != ST_RUN) begin
        por_flag_r <= 1'b0;
        sup_flag_r <= supply_trip;
        oth_flag_r <= !supply_trip && other_reset_req;
        soft_flag_r <= !supply_trip && soft_req;
      end
    end
  end

  // Supply monitor enable and reset source selection.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mon_en <= 1'b1;
      mon_src_r <= 1'b1;
    end else if (clk_en) begin
      if (wr_mon) begin
        mon_en <= reg_wdata[`REES_MON_EN_BIT];
        mon_src_r <= reg_wdata[`REES_MON_SRC_BIT];
      end else if (wr_cause) begin
        mon_src_r <= reg_wdata[`REES_CAUSE_POR_BIT];
      end
    end
  end

  // Pull-up disable and interrupt mask are ordinary special registers.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pull_dis_r <= 1'b0;
      int_mask_r <= `REES_MASK_RESET_VAL;
    end else if (clk_en) begin
      if (sfr_reset) begin
        pull_dis_r <= 1'b0;
        int_mask_r <= `REES_MASK_RESET_VAL;
      end else if (reg_wr && reg_addr == `REES_ADDR_PORT) begin
        pull_dis_r <= reg_wdata[`REES_PULL_DIS_BIT];
      end else if (reg_wr && reg_addr == `REES_ADDR_INT_MASK) begin
        int_mask_r <= reg_wdata[1:0];
      end
    end
  end

  // Sticky events survive internal resets so software can see them
  // after release; a set in the clearing cycle wins.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      int_stat_r <= 2'h0;
      supply_s_d_r <= 1'b0;
    end else if (clk_en) begin
      supply_s_d_r <= supply_s;
      for (int i = 0; i < 2; i++) begin
        if ((i == `REES_INT_EXIT_BIT && state_r == ST_SYNC) ||
            (i == `REES_INT_SUPPLY_BIT && supply_fall)) begin
          int_stat_r[i] <= 1'b1;
        end else if (in_run && reg_wr && reg_wdata[i] &&
                     reg_addr == `REES_ADDR_INT_STAT) begin
          int_stat_r[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(int_stat_r & int_mask_r);

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `REES_ADDR_CAUSE: begin
            reg_rdata <= {3'h0, soft_flag_r, 1'b0, oth_flag_r,
                          por_flag_r, sup_flag_r};
          end
          `REES_ADDR_MON: begin
            reg_rdata <= {mon_en, supply_s, 5'h00, mon_src_r};
          end
          `REES_ADDR_PORT: begin
            reg_rdata <= {7'h00, pull_dis_r};
          end
          `REES_ADDR_INT_STAT: begin
            reg_rdata <= {6'h00, int_stat_r};
          end
          `REES_ADDR_INT_MASK: begin
            reg_rdata <= {6'h00, int_mask_r};
          end
          default: begin
            reg_rdata <= 8'h00;
          end
        endcase
      end
    end
  end

  assign core_halt = !in_run;
  assign sfr_reset = !in_run;
  assign irq_timer_disable = !in_run;
  assign sp_reset = !in_run;
  assign exit_load = (state_r == ST_SYNC);
  assign port_force_default = !in_run;
  assign port_open_drain = !in_run;
  assign weak_pullup_en = !in_run || !pull_dis_r;

  assign reset_pin_low_out = 1'b0;
  assign reset_pin_low_oe = !in_run && state_r != ST_OTHER_HOLD &&
                            (por_path_r || sup_path_r);

  // Exit defaults are held in flops so the core samples stable data.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      fetch_addr <= `REES_PC_RESET_VAL;
      clk_sel <= REES_CLK_INTERNAL;
      wdt_en <= 1'b1;
      wdt_div <= `REES_WDT_DIV_VAL;
      port_latch_value <= `REES_PORT_RESET_VAL;
    end else if (clk_en) begin
      if (!in_run) begin
        fetch_addr <= `REES_PC_RESET_VAL;
        clk_sel <= REES_CLK_INTERNAL;
        wdt_en <= 1'b1;
        wdt_div <= `REES_WDT_DIV_VAL;
        port_latch_value <= `REES_PORT_RESET_VAL;
      end
    end
  end

  // Named steps of a release.
  sequence seq_sync_cycle;
    (state_r == ST_SYNC) && exit_load;
  endsequence

  sequence seq_released;
    !core_halt && in_run;
  endsequence

  AST_HALT_IN_RESET: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    in_run && (supply_trip || soft_req || other_reset_req) |=> core_halt)
    else $error("core not halted in reset");

  AST_SFR_DEFAULT: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    core_halt |=> (pull_dis_r == 1'b0) && (int_mask_r == 2'h0))
    else $error("special register default missing");

  AST_IRQ_TIMER_OFF: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    $rose(core_halt) |-> irq_timer_disable && sfr_reset)
    else $error("interrupts or timers left on");

  AST_SP_ONLY: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    sp_reset == core_halt)
    else $error("stack pointer reset mismatch");

  AST_PORT_DEFAULT: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    $past(core_halt) && core_halt |->
      port_latch_value == 8'hff && port_open_drain)
    else $error("port default wrong");

  AST_PULLUP: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    seq_sync_cycle |-> weak_pullup_en ##1 weak_pullup_en)
    else $error("pull-ups off around release");

  AST_PIN_LOW: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    (state_r == ST_POR_HOLD || state_r == ST_POR_DELAY ||
     state_r == ST_SUPPLY_HOLD) |-> reset_pin_low_oe && !reset_pin_low_out)
    else $error("reset pin not driven low");

  AST_EXIT_VALUES: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    seq_sync_cycle |-> fetch_addr == 16'h0000 &&
      clk_sel == REES_CLK_INTERNAL && wdt_en && wdt_div == 4'hc)
    else $error("exit defaults wrong");

  AST_POR_DELAY: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    (state_r == ST_POR_DELAY && state_nxt == ST_SYNC) |->
      dly_cnt_r == POR_LAST)
    else $error("power-on delay length wrong");

  AST_POR_FLAG: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    seq_sync_cycle ##0 por_path_r |=> por_flag_r && mon_en)
    else $error("power-on flag not set");

  AST_POR_CLEAR: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    (state_r == ST_OTHER_HOLD || state_r == ST_SUPPLY_HOLD) |-> !por_flag_r)
    else $error("power-on flag survived other reset");

  AST_NO_SUPPLY_DELAY: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    (state_r == ST_SUPPLY_HOLD && supply_s) |=> seq_sync_cycle ##1
      seq_released)
    else $error("delay applied after supply reset");

  AST_MON_KEEP: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    !in_run |=> $stable(mon_en))
    else $error("monitor enable changed by reset");

  AST_SYNC_RELEASE: assert property (@(posedge sys_clk)
    disable iff (!resetn || !clk_en)
    $fell(core_halt) |-> $past(exit_load))
    else $error("release without settle cycle");

endmodule : rees_seq

// ==== hw/rees_sync.sv ====
// Purpose: Two-flop synchroniser for a pin level.
// Assumes: One clock, synchronous active-low reset.
// Notes: Only the second flop is visible outside.
module rees_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Level in and out
  input wire logic pin_in,
  output logic level_out
);
  import rees_pkg::*;

  logic meta_r;

  // The first flop feeds only the second one.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_r <= 1'b0;
      level_out <= 1'b0;
    end else if (clk_en) begin
      meta_r <= pin_in;
      level_out <= meta_r;
    end
  end

endmodule : rees_sync

// ==== pkg/rees_defs.svh ====
// Purpose: Constants of the reset entry and exit sequencer.
// Assumes: Included by bare name; definitions only.
// Notes: Offsets index the plain register port, one byte per index.
`ifndef REES_DEFS_SVH
`define REES_DEFS_SVH

// Clock rate and timing.
`define REES_CLK_PERIOD_NS 4
`define REES_POR_DELAY_NS 300000
`define REES_POR_DELAY_CYC (`REES_POR_DELAY_NS / `REES_CLK_PERIOD_NS)
`define REES_OTHER_HOLD_CYC 3'h4

// Register offsets.
`define REES_ADDR_CAUSE 4'h0
`define REES_ADDR_MON 4'h1
`define REES_ADDR_PORT 4'h2
`define REES_ADDR_INT_STAT 4'h3
`define REES_ADDR_INT_MASK 4'h4

// Reset cause register fields.
`define REES_CAUSE_SUPPLY_BIT 0
`define REES_CAUSE_POR_BIT 1
`define REES_CAUSE_OTHER_BIT 2
`define REES_CAUSE_SOFT_BIT 4

// Supply monitor register fields.
`define REES_MON_SRC_BIT 0
`define REES_MON_STAT_BIT 6
`define REES_MON_EN_BIT 7

// Port control and interrupt fields.
`define REES_PULL_DIS_BIT 0
`define REES_INT_EXIT_BIT 0
`define REES_INT_SUPPLY_BIT 1

// Reset values.
`define REES_PORT_RESET_VAL 8'hff
`define REES_PC_RESET_VAL 16'h0000
`define REES_WDT_DIV_VAL 4'hc
`define REES_MASK_RESET_VAL 2'h0

`endif

// ==== pkg/rees_pkg.sv ====
// Purpose: Types of the reset entry and exit sequencer.
// Assumes: Nothing beyond SystemVerilog.
// Notes: States are one-hot.
package rees_pkg;

  // Sequencer states.
  typedef enum logic [5:0] {
    ST_POR_HOLD = 6'h01,
    ST_POR_DELAY = 6'h02,
    ST_SUPPLY_HOLD = 6'h04,
    ST_OTHER_HOLD = 6'h08,
    ST_SYNC = 6'h10,
    ST_RUN = 6'h20
  } rees_state_t;

  // System clock source choice.
  typedef enum logic {
    REES_CLK_INTERNAL = 1'b0,
    REES_CLK_EXTERNAL = 1'b1
  } rees_clk_src_t;

endpackage : rees_pkg

// ==== tb/rees_core_model.sv ====
// Purpose: Core and supply model on the far side of the sequencer.
// Assumes: One clock; the bench commands the supply level.
// Notes: Records the first fetch address after each release.
module rees_core_model (
  // Clock
  input wire logic sys_clk,
  // Supply command from the bench
  input wire logic supply_cmd,
  output logic supply_good,
  // Core control from the sequencer
  input wire logic core_halt,
  input wire logic exit_load,
  input wire logic [15:0] fetch_addr,
  // Observed fetch address
  output logic [15:0] first_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] pc_r;
  logic halted_r;

  // The supply pin simply follows the bench command.
  assign supply_good = supply_cmd;

  always_ff @(posedge sys_clk) begin
    halted_r <= core_halt;
    if (exit_load) begin
      pc_r <= fetch_addr;
    end else if (!core_halt) begin
      pc_r <= pc_r + 16'h0001;
    end
    if (!core_halt && halted_r) begin
      first_addr <= pc_r; // First fetch after release.
    end else if (core_halt && !halted_r) begin
      // Forget the last record so a stale zero cannot pass.
      first_addr <= 16'hffff;
    end
  end
endmodule : rees_core_model

// ==== tb/reset_entry_exit_sequencer_tb.sv ====
// Purpose: Self-checking bench of the reset sequencer.
// Assumes: Short power-on delay parameter for simulation.
// Notes: Register writes are only honoured while the core runs.
`include "rees_defs.svh"
module reset_entry_exit_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rees_pkg::*;
  localparam int unsigned PD = 8;
  logic sys_clk, resetn, reg_wr, reg_rd, supply_cmd, supply_good, oreq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, pl;
  logic core_halt, sfr_reset, itd, sp_reset, exit_load, wdt_en, mon_en;
  logic pfd, pod, wpu, rpo, rpoe, irq, cke;
  logic [15:0] fetch_addr, first_addr;
  logic [3:0] wdt_div;
  rees_clk_src_t clk_sel;
  int num_errors = 0;
  int cmp_count = 0;

  // Clock of 4 ns.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  rees_seq #(.POR_DELAY_CYC(PD)) DUT (.sys_clk(sys_clk), .resetn(resetn),
    .clk_en(cke), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .supply_good(supply_good), .other_reset_req(oreq),
    .core_halt(core_halt), .sfr_reset(sfr_reset), .irq_timer_disable(itd),
    .sp_reset(sp_reset), .exit_load(exit_load), .fetch_addr(fetch_addr),
    .clk_sel(clk_sel), .wdt_en(wdt_en), .wdt_div(wdt_div), .mon_en(mon_en),
    .port_force_default(pfd), .port_latch_value(pl), .port_open_drain(pod),
    .weak_pullup_en(wpu), .reset_pin_low_out(rpo), .reset_pin_low_oe(rpoe),
    .irq(irq));

  rees_core_model core (.sys_clk(sys_clk), .supply_cmd(supply_cmd),
    .supply_good(supply_good), .core_halt(core_halt),
    .exit_load(exit_load), .fetch_addr(fetch_addr),
    .first_addr(first_addr));

  // One comparison; values are zero-extended to 16 bits.
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic rdchk(input string nm, input logic [3:0] a,
                       input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask : rdchk

  // Defaults forced while the core is held.
  task automatic chk_in_reset(input logic oe);
    chk("halt", 16'h1, core_halt);
    chk("sfr", 16'h1, sfr_reset);
    chk("irq_tmr", 16'h1, itd);
    chk("sp", 16'h1, sp_reset);
    chk("latch", 16'h00ff, pl);
    chk("od", 16'h1, pod & pfd);
    chk("pull", 16'h1, wpu);
    chk("pin_oe", oe, rpoe);
    chk("pin_out", 16'h0, rpo);
    chk("fetch", `REES_PC_RESET_VAL, fetch_addr);
    chk("clk", REES_CLK_INTERNAL, clk_sel);
    chk("wdt", {12'h001, `REES_WDT_DIV_VAL},
        {11'h0, wdt_en, wdt_div});
  endtask : chk_in_reset

  // Count cycles until the core runs again.
  task automatic wait_run(output int n, output logic saw);
    n = 0;
    saw = 1'b0;
    while (core_halt !== 1'b0 && n < 200) begin
      @(posedge sys_clk);
      #1 n++;
      if (exit_load === 1'b1) saw = 1'b1;
    end
    // The core model logs its first fetch one edge after release.
    @(posedge sys_clk);
    #1;
  endtask : wait_run

  task automatic t_por;
    int n;
    logic s;
    chk_in_reset(1'b1);
    chk("mon_en", 16'h1, mon_en);
    @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (30) @(posedge sys_clk);
    #1 chk("por_wait", 16'h1, core_halt & rpoe);
    @(posedge sys_clk);
    supply_cmd <= 1'b1;
    wait_run(n, s);
    chk("por_min", 16'h1, n >= PD);
    chk("por_max", 16'h1, n <= PD + 4);
    chk("sync", 16'h1, s);
    chk("first", 16'h0000, first_addr);
    // Software learns the cause from the power-on flag.
    rdchk("cause", `REES_ADDR_CAUSE, 8'h02);
    rdchk("mon", `REES_ADDR_MON, 8'hc1);
    rdchk("stat", `REES_ADDR_INT_STAT, 8'h01);
    $display("test por done");
  endtask : t_por

  task automatic t_other;
    int n;
    logic s;
    wr(`REES_ADDR_PORT, 8'h01);
    wr(`REES_ADDR_MON, 8'h00);
    wr(`REES_ADDR_INT_MASK, 8'h01);
    #1 chk("pull_off", 16'h0, wpu);
    chk("irq_on", 16'h1, irq);
    wr(`REES_ADDR_INT_STAT, 8'h01);
    #1 chk("irq_clr", 16'h0, irq);
    @(posedge sys_clk);
    oreq <= 1'b1;
    @(posedge sys_clk);
    oreq <= 1'b0;
    #1 chk_in_reset(1'b0);
    wait_run(n, s);
    chk("hold", `REES_OTHER_HOLD_CYC + 1, n);
    chk("first", 16'h0000, first_addr);
    rdchk("cause", `REES_ADDR_CAUSE, 8'h04);
    rdchk("mon", `REES_ADDR_MON, 8'h40);
    chk("mon_en", 16'h0, mon_en);
    chk("pull_on", 16'h1, wpu);
    chk("irq_mask", 16'h0, irq);
    rdchk("stat", `REES_ADDR_INT_STAT, 8'h01);
    wr(`REES_ADDR_INT_MASK, 8'h01);
    #1 chk("irq_on", 16'h1, irq);
    wr(`REES_ADDR_INT_STAT, 8'h01);
    #1 chk("irq_clr", 16'h0, irq);
    $display("test other done");
  endtask : t_other

  task automatic t_soft;
    int n;
    logic s;
    wr(`REES_ADDR_CAUSE, 8'h10);
    #1 chk_in_reset(1'b0);
    wr(`REES_ADDR_MON, 8'h81);
    wait_run(n, s);
    rdchk("cause", `REES_ADDR_CAUSE, 8'h10);
    rdchk("mon", `REES_ADDR_MON, 8'h40);
    rdchk("unmapped", 4'hf, 8'h00);
    // A frozen clock enable must swallow a soft reset request.
    @(posedge sys_clk);
    cke <= 1'b0;
    wr(`REES_ADDR_CAUSE, 8'h10);
    #1 chk("frozen", 16'h0, core_halt);
    @(posedge sys_clk);
    cke <= 1'b1;
    rdchk("cause_kept", `REES_ADDR_CAUSE, 8'h10);
    $display("test soft done");
  endtask : t_soft

  task automatic t_supply;
    int n;
    logic s;
    wr(`REES_ADDR_MON, 8'h81);
    wr(`REES_ADDR_CAUSE, 8'h02);
    @(posedge sys_clk);
    supply_cmd <= 1'b0;
    n = 0;
    while (core_halt !== 1'b1 && n < 8) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk_in_reset(1'b1);
    repeat (20) @(posedge sys_clk);
    #1 chk("hold", 16'h1, core_halt);
    @(posedge sys_clk);
    supply_cmd <= 1'b1;
    wait_run(n, s);
    chk("fast", 16'h1, n <= 5 && n < PD);
    rdchk("cause", `REES_ADDR_CAUSE, 8'h01);
    rdchk("stat", `REES_ADDR_INT_STAT, 8'h03);
    chk("mon_en", 16'h1, mon_en);
    $display("test supply done");
  endtask : t_supply

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // Watchdog against a hang; the tests take well under 2000 cycles.
  initial begin
    #40000;
    num_errors++;
    final_report();
  end

  initial begin
    resetn = 1'b0;
    supply_cmd = 1'b0;
    oreq = 1'b0;
    cke = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    repeat (6) @(posedge sys_clk);
    #1;
    t_por();
    t_other();
    t_soft();
    t_supply();
    final_report();
  end
endmodule : reset_entry_exit_sequencer_tb
